/* hdl/pbpi_pkg.sv */
// Shared constants, register map and pin carriers for the bus pin interface.
// Assumes a single 200 MHz clock; bus pins arrive from outside and are resynchronised.
package pbpi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map of the plain software port (byte addresses).
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_STAT  = 8'h04;
    localparam logic [7:0] REG_MASK  = 8'h08;
    localparam logic [7:0] REG_MADDR = 8'h0C;
    localparam logic [7:0] REG_MDATA = 8'h10;
    localparam logic [7:0] REG_MCMD  = 8'h14;
    localparam logic [7:0] REG_TDATA = 8'h18;
    localparam logic [7:0] REG_TBASE = 8'h1C;
    localparam logic [7:0] REG_STATE = 8'h20;

    // Control bits; GO is a self-clearing pulse.
    localparam int unsigned CTRL_GO      = 0;
    localparam int unsigned CTRL_SERR_EN = 1;
    localparam int unsigned CTRL_INT_EN  = 2;
    localparam int unsigned CTRL_PME_EN  = 3;

    // Sticky status bits, write one to clear.
    localparam int unsigned ST_W        = 8;
    localparam int unsigned ST_DONE     = 0;
    localparam int unsigned ST_ABORT    = 1;
    localparam int unsigned ST_STOPPED  = 2;
    localparam int unsigned ST_PERR_DET = 3;
    localparam int unsigned ST_PERR_RPT = 4;
    localparam int unsigned ST_SERR     = 5;
    localparam int unsigned ST_TGT_WR   = 6;
    localparam int unsigned ST_PME      = 7;

    // Bus command encodings and decode fields.
    localparam logic [3:0] CMD_SPECIAL = 4'h1;
    localparam logic [2:0] CMD_CFG_HI  = 3'h5;
    localparam logic [2:0] CMD_MEM_HI  = 3'h3;
    localparam logic [1:0] CFG_DW_ID   = 2'h0;
    localparam logic [1:0] CFG_DW_BASE = 2'h1;
    localparam logic [7:0] BASE_RST    = 8'h00;
    localparam logic [3:0] MST_ABORT_CYC = 4'h6;

    ////////////////////////////////////////////////////////////////////////////
    // Pin carriers.
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0]  cbe_n;
        logic        par;
        logic        frame_n;
        logic        irdy_n;
        logic        trdy_n;
        logic        devsel_n;
        logic        stop_n;
        logic        perr_n;
        logic        idsel;
        logic        gnt_n;
    } pbpi_pin_in_t;

    typedef struct packed {
        logic [31:0] ad;
        logic [3:0]  cbe_n;
        logic        par;
        logic        frame_n;
        logic        irdy_n;
        logic        trdy_n;
        logic        devsel_n;
        logic        stop_n;
        logic        perr_n;
        logic        serr_n;
        logic        req_n;
        logic        inta_n;
        logic        pme_n;
    } pbpi_pin_out_t;

    typedef struct packed {
        logic ad;
        logic cbe;
        logic par;
        logic frame;
        logic irdy;
        logic trdy;
        logic devsel;
        logic stop;
        logic perr;
        logic serr;
        logic req;
        logic inta;
        logic pme;
    } pbpi_pin_oe_t;

    typedef enum logic [1:0] {T_IDLE, T_CLAIM, T_DATA, T_TURN} pbpi_tstate_t;
    typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN} pbpi_mstate_t;

endpackage

/* hdl/pbpi_top.sv */
// Bus pin interface: single-phase target and master, parity, error and event pins.
// Assumes bus pins are sampled by the 200 MHz clock; the testbench resolves pin levels from enables.
// What this block does
// - Claim configuration accesses only while the select pin is high.
// - Pull the interrupt pin low while an unmasked enabled status bit is set.
// - As master, drive initiator ready low only when able to finish.
// - A data phase completes only when both ready signals are low.
// - As target, drive target ready low only when ready to finish.
// - Parity makes address/data, byte enables and parity an even count of ones.
// - As master, drive parity for address and write data phases.
// - As target, drive parity for read data phases.
// - Every phase begins on a rising edge; no minimum clock rate assumed.
// - Drive parity error low on bad received data, except special cycles.
// - Event pin low only while event enable and event status are both set.
// - Signal an event when a power-state-changing event is detected.
// - Request the bus before starting any master transaction.
// - With error reporting on, pull system error low on address parity error.
// - Target stop ends a transaction; master honours a stop.
// - Target claims with device select; master checks device select.
// - Drive a shared low signal high one clock before floating it.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/100ps
module pbpi_top #(
    parameter logic [31:0] CFG_ID = 32'h0A5A_0001  // Arbitrary identity word.
) (
    // Clock and reset.
    input  wire logic                    mclk_i,
    input  wire logic                    rst_n_i,
    // Bus pins.
    input  wire pbpi_pkg::pbpi_pin_in_t  pin_i,
    output      pbpi_pkg::pbpi_pin_out_t pin_o,
    output      pbpi_pkg::pbpi_pin_oe_t  pin_oe_o,
    // Power event source.
    input  wire logic                    pme_event_i,
    // Register port.
    input  wire logic [7:0]              addr_i,
    input  wire logic [31:0]             wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output      logic [31:0]             rdata_o
);
    import pbpi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Two-flop resynchronisers; only the second stage is read.
    pbpi_pin_in_t sync1_q, bus_q;
    logic         frame_d1_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_q    <= '1;
            bus_q      <= '1;
            frame_d1_q <= 1'b1;
        end else begin
            sync1_q    <= pin_i;
            bus_q      <= sync1_q;
            frame_d1_q <= bus_q.frame_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software registers.
    logic [3:0]      ctrl_q;
    logic [ST_W-1:0] st_q, st_set, mask_q;
    logic [31:0]     maddr_q, mdata_q, tdata_q, tbase_q;
    logic [7:0]      mcmd_q;
    pbpi_tstate_t    ts_q;
    pbpi_mstate_t    ms_q;
    logic            go;
    logic            t_xfer, m_xfer, t_start, t_wr, m_wr;
    logic            t_hit_cfg, t_hit_mem;
    logic [3:0]      t_cmd_q;
    logic [1:0]      t_dw_q;
    logic            t_cfg_q;

    assign go = wr_i && (addr_i == REG_CTRL) && wdata_i[CTRL_GO];

    // Control, mask, master address and master command registers.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q  <= '0;
            mask_q  <= '0;
            maddr_q <= '0;
            mcmd_q  <= '0;
        end else if (wr_i) begin
            unique case (addr_i)
                REG_CTRL:  ctrl_q  <= {wdata_i[3:1], 1'b0};
                REG_MASK:  mask_q  <= wdata_i[ST_W-1:0];
                REG_MADDR: maddr_q <= wdata_i;
                REG_MCMD:  mcmd_q  <= wdata_i[7:0];
                default:   ctrl_q  <= ctrl_q;
            endcase
        end
    end

    // Target data and base may be written by software or by a bus write; the bus wins.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tdata_q <= '0;
            tbase_q <= {BASE_RST, 24'h00_0000};
        end else if (t_xfer && t_wr) begin
            if (!t_cfg_q)
                tdata_q <= bus_q.ad;
            else if (t_dw_q == CFG_DW_BASE)
                tbase_q <= bus_q.ad;
        end else if (wr_i && addr_i == REG_TDATA) begin
            tdata_q <= wdata_i;
        end else if (wr_i && addr_i == REG_TBASE) begin
            tbase_q <= wdata_i;
        end
    end

    // Master data: software loads write data, a master read returns its data here.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            mdata_q <= '0;
        else if (m_xfer && !m_wr)
            mdata_q <= bus_q.ad;
        else if (wr_i && addr_i == REG_MDATA)
            mdata_q <= wdata_i;
    end

    // Sticky status; a set in the clearing cycle survives.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            st_q <= '0;
        else if (wr_i && addr_i == REG_STAT)
            st_q <= (st_q & ~wdata_i[ST_W-1:0]) | st_set;
        else
            st_q <= st_q | st_set;
    end

    // Read data in the cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rdata_o <= '0;
        else if (rd_i) begin
            unique case (addr_i)
                REG_CTRL:  rdata_o <= {28'h000_0000, ctrl_q};
                REG_STAT:  rdata_o <= {24'h00_0000, st_q};
                REG_MASK:  rdata_o <= {24'h00_0000, mask_q};
                REG_MADDR: rdata_o <= maddr_q;
                REG_MDATA: rdata_o <= mdata_q;
                REG_MCMD:  rdata_o <= {24'h00_0000, mcmd_q};
                REG_TDATA: rdata_o <= tdata_q;
                REG_TBASE: rdata_o <= tbase_q;
                REG_STATE: rdata_o <= {27'h000_0000, 3'(ms_q), 2'(ts_q)};
                default:   rdata_o <= '0;
            endcase
        end else
            rdata_o <= '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Target side: one data phase per access, stop asked when the master wants more.
    logic trdy_q, devsel_q, stop_q, t_oe_q;
    assign t_start   = !bus_q.frame_n && frame_d1_q && (ms_q == M_IDLE || ms_q == M_REQ);
    assign t_hit_cfg = (bus_q.cbe_n[3:1] == CMD_CFG_HI) && bus_q.idsel;
    assign t_hit_mem = (bus_q.cbe_n[3:1] == CMD_MEM_HI) && (bus_q.ad[31:8] == tbase_q[31:8]);
    assign t_wr      = t_cmd_q[0];
    assign t_xfer    = (ts_q == T_DATA) && !trdy_q && !bus_q.irdy_n;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ts_q     <= T_IDLE;
            trdy_q   <= 1'b1;
            devsel_q <= 1'b1;
            stop_q   <= 1'b1;
            t_oe_q   <= 1'b0;
            t_cmd_q  <= '0;
            t_dw_q   <= '0;
            t_cfg_q  <= 1'b0;
        end else begin
            unique case (ts_q)
                T_IDLE: if (t_start && (t_hit_cfg || t_hit_mem)) begin
                    ts_q     <= T_CLAIM;
                    devsel_q <= 1'b0;
                    t_oe_q   <= 1'b1;
                    t_cmd_q  <= bus_q.cbe_n;
                    t_dw_q   <= bus_q.ad[3:2];
                    t_cfg_q  <= t_hit_cfg;
                end
                T_CLAIM: begin
                    ts_q   <= T_DATA;
                    trdy_q <= 1'b0;
                    stop_q <= bus_q.frame_n;
                end
                T_DATA: if (t_xfer) begin
                    ts_q     <= T_TURN;
                    trdy_q   <= 1'b1;
                    devsel_q <= 1'b1;
                    stop_q   <= 1'b1;
                end
                T_TURN: begin
                    ts_q   <= T_IDLE;
                    t_oe_q <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master side: request, address phase, one data phase, turnaround.
    logic       frame_q, irdy_q, req_q, m_oe_q;
    logic [3:0] m_tmo_q;
    assign m_wr   = mcmd_q[0];
    assign m_xfer = (ms_q == M_DATA) && !irdy_q && !bus_q.trdy_n && !bus_q.devsel_n;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ms_q    <= M_IDLE;
            frame_q <= 1'b1;
            irdy_q  <= 1'b1;
            req_q   <= 1'b1;
            m_oe_q  <= 1'b0;
            m_tmo_q <= '0;
        end else begin
            unique case (ms_q)
                M_IDLE: if (go) begin
                    ms_q  <= M_REQ;
                    req_q <= 1'b0;
                end
                M_REQ: if (!bus_q.gnt_n && bus_q.frame_n && bus_q.irdy_n && ts_q == T_IDLE) begin
                    ms_q    <= M_ADDR;
                    frame_q <= 1'b0;
                    req_q   <= 1'b1;
                    m_oe_q  <= 1'b1;
                end
                M_ADDR: begin
                    ms_q    <= M_DATA;
                    frame_q <= 1'b1;
                    irdy_q  <= 1'b0;
                    m_tmo_q <= '0;
                end
                M_DATA: begin
                    m_tmo_q <= m_tmo_q + 4'h1;
                    if (m_xfer || !bus_q.stop_n || (bus_q.devsel_n && m_tmo_q == MST_ABORT_CYC)) begin
                        ms_q   <= M_TURN;
                        irdy_q <= 1'b1;
                    end
                end
                M_TURN: begin
                    ms_q   <= M_IDLE;
                    m_oe_q <= 1'b0;
                end
                default: ms_q <= M_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared address/data driver and parity, which lags its data by one clock.
    logic [31:0] ad_q;
    logic [3:0]  cbe_q;
    logic        ad_oe_q, cbe_oe_q, par_q, par_oe_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ad_q     <= '0;
            cbe_q    <= '1;
            ad_oe_q  <= 1'b0;
            cbe_oe_q <= 1'b0;
            par_q    <= 1'b0;
            par_oe_q <= 1'b0;
        end else begin
            par_q    <= ^{ad_q, cbe_q};
            par_oe_q <= ad_oe_q;
            if (ms_q == M_REQ && !bus_q.gnt_n && bus_q.frame_n && bus_q.irdy_n && ts_q == T_IDLE) begin
                ad_q     <= maddr_q;
                cbe_q    <= mcmd_q[3:0];
                ad_oe_q  <= 1'b1;
                cbe_oe_q <= 1'b1;
            end else if (ms_q == M_ADDR) begin
                ad_q    <= mdata_q;
                cbe_q   <= mcmd_q[7:4];
                ad_oe_q <= m_wr;
            end else if (ts_q == T_IDLE && t_start && (t_hit_cfg || t_hit_mem) && !bus_q.cbe_n[0]) begin
                ad_q    <= !t_hit_cfg ? tdata_q : (bus_q.ad[3:2] == CFG_DW_ID) ? CFG_ID : tbase_q;
                ad_oe_q <= 1'b1;
            end else if (m_xfer || ms_q == M_TURN || t_xfer || ts_q == T_TURN) begin
                ad_oe_q  <= 1'b0;
                cbe_oe_q <= 1'b0;
            end else if (ms_q == M_DATA && ms_q != M_IDLE && (!bus_q.stop_n || m_tmo_q == MST_ABORT_CYC)) begin
                ad_oe_q  <= 1'b0;
                cbe_oe_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parity checking of received data and of address phases, one clock later.
    logic chk_pend_q, chk_addr_q, chk_exp_q;
    logic [1:0] perr_ph_q;
    logic serr_q;
    logic bad_par;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            chk_pend_q <= 1'b0;
            chk_addr_q <= 1'b0;
            chk_exp_q  <= 1'b0;
        end else begin
            chk_pend_q <= t_start || (t_xfer && t_wr) || (m_xfer && !m_wr && mcmd_q[3:0] != CMD_SPECIAL);
            chk_addr_q <= t_start;
            chk_exp_q  <= ^{bus_q.ad, bus_q.cbe_n};
        end
    end
    assign bad_par = chk_pend_q && (chk_exp_q != bus_q.par);

    // Parity error pin: low one clock, high one clock, then float.
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            perr_ph_q <= 2'h0;
            serr_q    <= 1'b0;
        end else begin
            serr_q <= bad_par && chk_addr_q && ctrl_q[CTRL_SERR_EN];
            if (bad_par && !chk_addr_q)
                perr_ph_q <= 2'h1;
            else if (perr_ph_q == 2'h1)
                perr_ph_q <= 2'h2;
            else
                perr_ph_q <= 2'h0;
        end
    end

    // Events that set status bits.
    always_comb begin
        st_set              = '0;
        st_set[ST_DONE]     = m_xfer;
        st_set[ST_ABORT]    = ms_q == M_DATA && bus_q.devsel_n && m_tmo_q == MST_ABORT_CYC;
        st_set[ST_STOPPED]  = ms_q == M_DATA && !m_xfer && !bus_q.stop_n;
        st_set[ST_PERR_DET] = bad_par && !chk_addr_q;
        st_set[ST_PERR_RPT] = (ms_q == M_DATA || ms_q == M_TURN) && m_wr
                              && mcmd_q[3:0] != CMD_SPECIAL && !bus_q.perr_n;
        st_set[ST_SERR]     = bad_par && chk_addr_q;
        st_set[ST_TGT_WR]   = t_xfer && t_wr;
        st_set[ST_PME]      = pme_event_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain interrupt and event pins; pulled low only, floating otherwise.
    logic inta_q, pme_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inta_q <= 1'b0;
            pme_q  <= 1'b0;
        end else begin
            inta_q <= ctrl_q[CTRL_INT_EN] && |(st_q & mask_q);
            pme_q  <= ctrl_q[CTRL_PME_EN] && st_q[ST_PME];
        end
    end

    // Request enable stays off in reset so that every output floats then.
    logic req_oe_q;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            req_oe_q <= 1'b0;
        else
            req_oe_q <= 1'b1;
    end

    // Pin assembly straight from flops; enables are zero throughout reset.
    assign pin_o = '{ad: ad_q, cbe_n: cbe_q, par: par_q, frame_n: frame_q, irdy_n: irdy_q,
                     trdy_n: trdy_q, devsel_n: devsel_q, stop_n: stop_q, perr_n: perr_ph_q != 2'h1,
                     serr_n: 1'b0, req_n: req_q, inta_n: 1'b0, pme_n: 1'b0};
    assign pin_oe_o = '{ad: ad_oe_q, cbe: cbe_oe_q, par: par_oe_q, frame: m_oe_q, irdy: m_oe_q,
                        trdy: t_oe_q, devsel: t_oe_q, stop: t_oe_q, perr: perr_ph_q != 2'h0,
                        serr: serr_q, req: req_oe_q, inta: inta_q, pme: pme_q};

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_addr_phase;
        ms_q == M_ADDR && !frame_q;
    endsequence
    sequence s_perr_tail;
        pin_o.perr_n && pin_oe_o.perr ##1 !pin_oe_o.perr;
    endsequence

    chk_inta_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        inta_q == $past(ctrl_q[CTRL_INT_EN] && |(st_q & mask_q))) else $error("interrupt pin wrong");
    chk_pme_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pme_q |-> $past(ctrl_q[CTRL_PME_EN] && st_q[ST_PME])) else $error("event pin without gate");
    chk_irdy_after: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        s_addr_phase |=> !irdy_q && frame_q) else $error("initiator ready late");
    chk_trdy_claim: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !trdy_q |-> !devsel_q && t_oe_q) else $error("target ready without claim");
    chk_req_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $fell(frame_q) |-> $past(!req_q) && $past(!bus_q.gnt_n)) else $error("frame without request");
    chk_par_even: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        par_oe_q |-> ^{$past(ad_q), $past(cbe_q), par_q} == 1'b0) else $error("parity odd");
    chk_perr_phase: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !pin_o.perr_n |=> s_perr_tail) else $error("parity error pin sequence");
    chk_turn_high: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $fell(t_oe_q) |-> $past(trdy_q && devsel_q && stop_q)) else $error("floated while low");
    chk_abort_bound: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ms_q == M_ADDR |-> ##[1:9] ms_q == M_TURN) else $error("master never ends");
    chk_cfg_select: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(t_oe_q) && t_cfg_q |-> $past(bus_q.idsel)) else $error("config claim without select");
endmodule

/* bench/pbpi_bus_model.sv */
// Far side of the bus: arbiter, pull-ups and a memory target for master writes.
// Assumes the device's pin values and enables; returns resolved wire levels.
`timescale 1ns/100ps
module pbpi_bus_model
    import pbpi_pkg::*;
(
    // Device side.
    input  wire logic          mclk_i,
    input  wire logic          slow_i,
    input  wire pbpi_pin_out_t dev_i,
    input  wire pbpi_pin_oe_t  oe_i,
    // Wires and parity error count.
    output      pbpi_pin_in_t  bus_o,
    output      logic [7:0]    perr_cnt_o = 8'h00
);
    logic        act_q = 1'b0;
    logic        wt_q  = 1'b0;
    logic        ans_q = 1'b0;
    logic        chk_q = 1'b0;
    logic        par_q = 1'b0;
    logic [31:0] ad_q  = 32'h0;
    // Claim after frame, answer at once or a cycle late, let go after the transfer edge.
    always @(posedge mclk_i) begin
        ad_q <= bus_o.ad;
        if (oe_i.frame && !dev_i.frame_n) act_q <= 1'b1;
        wt_q <= act_q;
        if (act_q && (wt_q || !slow_i)) ans_q <= 1'b1;
        // Hold ready until the device lets initiator ready go, as it sees ours two clocks late.
        if (ans_q && oe_i.irdy && dev_i.irdy_n) begin
            act_q <= 1'b0;
            ans_q <= 1'b0;
        end
        chk_q <= oe_i.ad && oe_i.cbe;
        par_q <= ^{dev_i.ad, dev_i.cbe_n};
        if (chk_q && oe_i.par && dev_i.par !== par_q) perr_cnt_o <= perr_cnt_o + 8'h01;
    end
    // Released lines float high through pull-ups; a released bus wanders, so stale data never matches.
    always_comb begin
        bus_o.ad       = oe_i.ad ? dev_i.ad : ~ad_q;
        bus_o.cbe_n    = oe_i.cbe ? dev_i.cbe_n : ~ad_q[3:0];
        bus_o.par      = oe_i.par ? dev_i.par : ~ad_q[4];
        bus_o.frame_n  = oe_i.frame ? dev_i.frame_n : 1'b1;
        bus_o.irdy_n   = oe_i.irdy ? dev_i.irdy_n : 1'b1;
        bus_o.trdy_n   = oe_i.trdy ? dev_i.trdy_n : !ans_q;
        bus_o.devsel_n = oe_i.devsel ? dev_i.devsel_n : !ans_q;
        bus_o.stop_n   = oe_i.stop ? dev_i.stop_n : 1'b1;
        bus_o.perr_n   = oe_i.perr ? dev_i.perr_n : 1'b1;
        bus_o.idsel    = 1'b0;
        bus_o.gnt_n    = !(oe_i.req && !dev_i.req_n);
    end
endmodule

/* bench/pci_bus_pin_interface_tb_top.sv */
// Bench for the bus pin interface: reset, registers, power event, interrupt and master writes.
// Assumes the bus model answers as arbiter and target.
`timescale 1ns/100ps
module pci_bus_pin_interface_tb_top;
    import pbpi_pkg::*;
    logic          mclk_i  = 1'b0;
    logic          rst_n_i = 1'b0;
    logic          pme_event_i = 1'b0;
    logic          wr_i    = 1'b0;
    logic          rd_i    = 1'b0;
    logic          slow_q  = 1'b0;
    logic [7:0]    addr_i  = 8'h00;
    logic [31:0]   wdata_i = 32'h0;
    logic [31:0]   rdata_o;
    logic [31:0]   rnd_q   = 32'h0001_69BD;
    logic [31:0]   v;
    logic [7:0]    perr_cnt;
    pbpi_pin_in_t  pin_i;
    pbpi_pin_out_t pin_o;
    pbpi_pin_oe_t  pin_oe_o;
    int            fail_count  = 0;
    int            checks_done = 0;
    int            cyc = 0;
    pbpi_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
        .pme_event_i(pme_event_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
    pbpi_bus_model i_bus (.mclk_i(mclk_i), .slow_i(slow_q), .dev_i(pin_o), .oe_i(pin_oe_o), .bus_o(pin_i),
        .perr_cnt_o(perr_cnt));
    // Clock, and a ceiling far above the fewer than two hundred cycles the tests need.
    always #2.5 mclk_i = !mclk_i;
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobe is dropped with an idle cycle after it, so tasks can follow each other safely.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
        @(posedge mclk_i);
    endtask
    task automatic final_report;
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence.
    initial begin
        repeat (8) @(posedge mclk_i);
        chk({19'h0, pin_oe_o}, 32'h0);
        repeat (8) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        rd(REG_TBASE, v);
        chk(v, 32'h0);
        rd(8'hFC, v);
        chk(v, 32'h0);
        pme_event_i <= 1'b1;
        @(posedge mclk_i);
        pme_event_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            wr(k == 2 ? REG_STAT : REG_CTRL, k == 0 ? 32'h0 : (k == 1 ? 32'h8 : 32'h80));
            #1;
            chk({31'h0, pin_oe_o.pme}, {31'h0, k == 1});
        end
        for (int i = 0; i < 6; i++) begin
            rnd_q = lfsr(rnd_q);
            slow_q <= rnd_q[0];
            wr(REG_MADDR, rnd_q);
            wr(REG_MDATA, ~rnd_q);
            wr(REG_MCMD, 32'h07);
            wr(REG_MASK, {31'h0, rnd_q[1]});
            wr(REG_CTRL, 32'h5);
            v = 32'h0;
            for (int n = 0; n < 40 && v[ST_DONE] !== 1'b1; n++) rd(REG_STAT, v);
            chk(v, 32'h1);
            #1;
            chk({31'h0, pin_oe_o.inta}, {31'h0, rnd_q[1]});
            wr(REG_STAT, 32'hFF);
            #1;
            chk({31'h0, pin_oe_o.inta}, 32'h0);
        end
        chk({24'h0, perr_cnt}, 32'h0);
        final_report();
    end
endmodule
